// ==== shared/svwd_pkg.sv ====
// Package for the supervisor reset generator: timing counts and output polarity.
// Assumes a 200 MHz clk; long periods are also top-level parameters.
package svwd_pkg;
  // Clock period in picoseconds
  localparam int unsigned CLK_PERIOD_PS = 5000;
  // Least kick level width, ns, and its cycle count (rounded up)
  localparam int unsigned KICK_MIN_NS   = 100;
  localparam int unsigned KICK_MIN_CYC  =
    (KICK_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Reset hold period, ms, and its cycle count (least time, rounded up)
  localparam int unsigned HOLD_MS       = 150;
  localparam longint unsigned HOLD_CYC  =
    (64'(HOLD_MS) * 64'd1000000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Watchdog timeout period, ms (plain default), and its cycle count
  localparam int unsigned WD_TIMEOUT_MS = 1600;
  localparam longint unsigned WD_CYC    =
    (64'(WD_TIMEOUT_MS) * 64'd1000000000) / CLK_PERIOD_PS;
  // Counter width for the watchdog and hold timers
  localparam int unsigned CNT_W         = 32;
  // Output polarity variants
  localparam bit POL_ACTIVE_LOW         = 1'b0;
  localparam bit POL_ACTIVE_HIGH        = 1'b1;
endpackage : svwd_pkg

// ==== rtl/svwd_supervisor.sv ====
// Reset generator of a processor supervisor: watchdog, reset sources, hold stretch.
// Assumes all level inputs are asynchronous digital comparator/pin results.
// Contract
// RULE_01: A kick level change that stands at least 100 ns restarts the watchdog timer.
// RULE_02: A kick held past the timeout expires the timer and gives a reset of the hold period.
// RULE_03: The watchdog timer is cleared whenever reset is asserted, from any source.
// RULE_04: A kick that never changes yields one reset pulse after every timeout period.
// RULE_05: Auxiliary comparator reporting below reference holds reset as a level.
// RULE_06: Supply below threshold asserts reset, stretched at least 150 ms after recovery.
// RULE_07: Manual reset held low asserts reset.
// RULE_08: Battery mode holds reset, drives the battery indicator high, ignores other inputs.
// RULE_09: Battery mode is never entered while the supply is above threshold.
// RULE_10: Reset output polarity is a build option and is valid whenever asserted.
// RULE_11: Host software should toggle the kick at separate program points.
// RULE_12: After manual reset returns high, reset stays for at least 150 ms.
// RULE_13: After the auxiliary input recovers, reset stays for the hold period.
// RULE_14: Battery mode needs supply below threshold and below backup supply together.
// RULE_15: Timeout and hold are counts of the clock; hold restarts while any source is active.
// RULE_16: Kick, manual reset and comparator levels are synchronised before use.
`timescale 1ns/100ps
`default_nettype none
module svwd_supervisor #(
  parameter bit                  RESET_POLARITY = svwd_pkg::POL_ACTIVE_LOW,
  parameter logic [31:0]         WD_CYCLES      = 32'(svwd_pkg::WD_CYC),
  parameter logic [31:0]         HOLD_CYCLES    = 32'(svwd_pkg::HOLD_CYC)
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Host watchdog and manual reset
  input  wire logic watchdog_kick_in,
  input  wire logic manual_reset_n,
  // Comparator levels
  input  wire logic supply_below_threshold,
  input  wire logic aux_below_reference,
  input  wire logic supply_below_backup,
  // Outputs
  output logic      reset_out,
  output logic      reset_active,
  output logic      battery_mode_out
);

  // Three-stage synchronisers, bit order: kick, mr_n, supply_low, aux_low, below_backup_supply_in
  logic [4:0] sync_a;
  logic [4:0] sync_b;
  logic [4:0] sync_c;
  logic [4:0] stable;

  // Synchroniser chain
  always_ff @(posedge clk) begin
    if (rst) begin
      sync_a <= 5'h02;
      sync_b <= 5'h02;
      sync_c <= 5'h02;
    end else begin
      sync_a <= {supply_below_backup, aux_below_reference, supply_below_threshold,
                 manual_reset_n, watchdog_kick_in}; // [RULE_16]
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  // Accept a level once second and third stages agree
  always_ff @(posedge clk) begin
    if (rst) begin
      stable <= 5'h06; // Start with supply low: power-on reset behaves as brownout
    end else begin
      for (int i = 0; i < 5; i++) begin
        if (sync_b[i] == sync_c[i]) begin
          stable[i] <= sync_c[i]; // [RULE_16]
        end
      end
    end
  end

  // Bit positions within the synchroniser word
  localparam int unsigned IDX_KICK = 0;
  localparam int unsigned IDX_MR   = 1;
  localparam int unsigned IDX_SUP  = 2;
  localparam int unsigned IDX_AUX  = 3;
  localparam int unsigned IDX_BACKUP_SUPPLY_IN = 4;

  // Accepted levels, named by source
  logic kick;
  logic mr_low;
  logic supply_low;
  logic aux_low;
  logic below_backup_supply_in;
  assign kick       = stable[IDX_KICK];
  assign mr_low     = ~stable[IDX_MR];
  assign supply_low = stable[IDX_SUP];
  assign aux_low    = stable[IDX_AUX];
  assign below_backup_supply_in = stable[IDX_BACKUP_SUPPLY_IN];

  // Battery mode: both conditions needed
  logic backup_supply_in_mode;
  assign backup_supply_in_mode = supply_low & below_backup_supply_in; // [RULE_14] [RULE_09]

  // Kick pulse filter: a new level must stand KICK_MIN_CYC cycles
  logic [7:0] kick_cnt;
  logic [7:0] next_kick_cnt;
  logic       kick_level;
  logic       next_kick_level;
  logic       kick_event;
  assign kick_event = (kick != kick_level) &&
                      (kick_cnt >= 8'(svwd_pkg::KICK_MIN_CYC - 1));

  // Next filter state: count while the level differs, adopt it once long enough
  always_comb begin
    next_kick_cnt   = kick_cnt;
    next_kick_level = kick_level;
    if (kick == kick_level) begin
      next_kick_cnt = 8'h00; // Short glitch dropped
    end else if (kick_event) begin
      next_kick_level = kick; // [RULE_01]
      next_kick_cnt   = 8'h00;
    end else begin
      next_kick_cnt = kick_cnt + 8'h01;
    end
  end

  // Filter registers
  always_ff @(posedge clk) begin
    if (rst) begin
      kick_cnt   <= 8'h00;
      kick_level <= 1'b0;
    end else begin
      kick_cnt   <= next_kick_cnt;
      kick_level <= next_kick_level;
    end
  end

  // Level sources, all masked in battery mode except supply
  logic level_src;
  assign level_src = supply_low | (~backup_supply_in_mode & (mr_low | aux_low)); // [RULE_05] [RULE_07] [RULE_08]

  // Watchdog timer and expiry pulse
  logic [31:0] wd_cnt;
  logic [31:0] next_wd_cnt;
  logic        wd_expire;
  assign wd_expire = ~reset_active && ~backup_supply_in_mode && (wd_cnt == WD_CYCLES - 32'h1);

  // Next watchdog count: cleared by reset, battery mode, kick or expiry
  always_comb begin
    if (reset_active || backup_supply_in_mode) begin
      next_wd_cnt = 32'h0; // [RULE_03] [RULE_08]
    end else if (kick_event) begin
      next_wd_cnt = 32'h0; // [RULE_01]
    end else if (wd_expire) begin
      next_wd_cnt = 32'h0; // [RULE_04]
    end else begin
      next_wd_cnt = wd_cnt + 32'h1; // [RULE_15]
    end
  end

  // Watchdog count register
  always_ff @(posedge clk) begin
    if (rst) begin
      wd_cnt <= 32'h0;
    end else begin
      wd_cnt <= next_wd_cnt;
    end
  end

  // Hold stretch: reloads while any source is active, counts down after
  logic [31:0] hold_cnt;
  logic [31:0] next_hold_cnt;

  // Next hold count
  always_comb begin
    if (level_src || wd_expire) begin
      next_hold_cnt = HOLD_CYCLES; // [RULE_15] [RULE_02] [RULE_06] [RULE_12] [RULE_13]
    end else if (hold_cnt != 32'h0) begin
      next_hold_cnt = hold_cnt - 32'h1;
    end else begin
      next_hold_cnt = hold_cnt;
    end
  end

  // Hold count register
  always_ff @(posedge clk) begin
    if (rst) begin
      hold_cnt <= 32'h0;
    end else begin
      hold_cnt <= next_hold_cnt;
    end
  end

  // Reset request: any live source, an expiry, or the hold count still above one
  function automatic logic reset_request(input logic src, input logic expire,
                                         input logic [31:0] hold);
    return src || expire || (hold > 32'h1);
  endfunction : reset_request

  // Pin level for a reset state under the build polarity
  function automatic logic pin_level(input logic asserted);
    return asserted ? RESET_POLARITY : ~RESET_POLARITY;
  endfunction : pin_level

  logic next_reset;
  assign next_reset = reset_request(level_src, wd_expire, hold_cnt); // [RULE_06]

  // Registered reset and polarised pin, asserted while rst stands
  always_ff @(posedge clk) begin
    if (rst) begin
      reset_active <= 1'b1;
      reset_out    <= pin_level(1'b1); // [RULE_10]
    end else begin
      reset_active <= next_reset; // [RULE_06]
      reset_out    <= pin_level(next_reset); // [RULE_10]
    end
  end

  // Battery indicator, one cycle behind the mode decision
  always_ff @(posedge clk) begin
    if (rst) begin
      battery_mode_out <= 1'b0;
    end else begin
      battery_mode_out <= backup_supply_in_mode; // [RULE_08]
    end
  end

endmodule : svwd_supervisor
`default_nettype wire

// ==== bench/svwd_supervisor_chk.sv ====
// Checker for the supervisor reset generator, bound to its top ports.
// Assumes a single clk domain and the synchronous rst.
`timescale 1ns/100ps
`default_nettype none
module svwd_chk #(
  parameter bit          RESET_POLARITY = 1'b0,
  parameter logic [31:0] WD_CYCLES      = 32'h64,
  parameter logic [31:0] HOLD_CYCLES    = 32'h14
) (
  // Clock, reset and host inputs
  input wire logic clk, rst, watchdog_kick_in, manual_reset_n,
  // Comparator levels
  input wire logic supply_below_threshold, aux_below_reference, supply_below_backup,
  // Outputs under watch
  input wire logic reset_out, reset_active, battery_mode_out
);
  logic [31:0] run, quiet;
  logic        kick_q;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Length of the reset run and of the unkicked stretch
  always_ff @(posedge clk) begin
    kick_q <= watchdog_kick_in;
    run    <= (rst || !reset_active) ? 32'h0 : run + 32'h1;
    quiet  <= (rst || reset_active || watchdog_kick_in != kick_q) ? 32'h0 : quiet + 32'h1;
  end
  pol_level_a: assert property (reset_out == (reset_active ? RESET_POLARITY : !RESET_POLARITY))
    else $error("reset level wrong");
  manual_src_a: assert property (!manual_reset_n [*8] |-> reset_active)
    else $error("manual low without reset");
  aux_src_a: assert property (aux_below_reference [*8] |-> reset_active)
    else $error("aux low without reset");
  supply_src_a: assert property (supply_below_threshold [*8] |-> reset_active)
    else $error("supply low without reset");
  backup_supply_in_reset_a: assert property (battery_mode_out |-> reset_active)
    else $error("battery mode without reset");
  backup_supply_in_enter_a: assert property ((supply_below_threshold && supply_below_backup) [*8] |-> battery_mode_out)
    else $error("battery mode not entered");
  backup_supply_in_block_a: assert property (!supply_below_threshold [*8] |-> !battery_mode_out)
    else $error("battery mode with good supply");
  hold_len_a: assert property ($fell(reset_active) |-> run >= HOLD_CYCLES)
    else $error("reset pulse too short");
  wd_expire_a: assert property (quiet <= WD_CYCLES + 32'h1E)
    else $error("watchdog did not expire");
  cover property ($rose(battery_mode_out));
  cover property ($fell(reset_active));
  cover property (quiet == WD_CYCLES);
endmodule : svwd_chk
bind svwd_supervisor svwd_chk #(.RESET_POLARITY(RESET_POLARITY), .WD_CYCLES(WD_CYCLES),
  .HOLD_CYCLES(HOLD_CYCLES)) chk_i (.clk(clk), .rst(rst), .watchdog_kick_in(watchdog_kick_in),
  .manual_reset_n(manual_reset_n), .supply_below_threshold(supply_below_threshold),
  .aux_below_reference(aux_below_reference), .supply_below_backup(supply_below_backup),
  .reset_out(reset_out), .reset_active(reset_active), .battery_mode_out(battery_mode_out));
`default_nettype wire

// ==== bench/svwd_host_model.sv ====
// Host model: flips the kick at separate program points while it runs.
// Assumes the bench enables it; it stands still while held in reset.
`timescale 1ns/100ps
`default_nettype none
module svwd_host_model #(parameter int PERIOD = 40) (
  // Clock, reset seen by the host, run enable
  input wire logic  clk, reset_active, run_en,
  // Kick line
  output var logic  kick = 1'b0
);
  int n = 0;
  // Loop start drives one level, subroutine entry the other
  always @(posedge clk) begin
    if (run_en && !reset_active) begin
      n <= (n == PERIOD - 1) ? 0 : n + 1;
      if (n == PERIOD - 1) kick <= #1 !kick; // Each level stands PERIOD cycles
    end
  end
endmodule : svwd_host_model
`default_nettype wire

// ==== bench/tb.sv ====
// Bench for the supervisor reset generator: watchdog, sources, hold, battery.
// Assumes the host model drives the kick; the bench drives the other inputs.
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam logic [31:0] WD = 32'h64, HOLD = 32'h14;
  logic clk = 0, rst = 1, mr_n = 1, sup = 0, aux = 0, bak = 0, run_en = 0;
  wire logic kick, rout, ract, backup_supply_in;
  int bad_count = 0, checks = 0, cyc = 0, n;
  // 5 ns clock
  initial forever #2.5 clk = !clk;
  svwd_host_model #(.PERIOD(40)) host (.clk(clk), .reset_active(ract), .run_en(run_en), .kick(kick));
  svwd_supervisor #(.WD_CYCLES(WD), .HOLD_CYCLES(HOLD)) dut (.clk(clk), .rst(rst),
    .watchdog_kick_in(kick), .manual_reset_n(mr_n), .supply_below_threshold(sup),
    .aux_below_reference(aux), .supply_below_backup(bak), .reset_out(rout),
    .reset_active(ract), .battery_mode_out(backup_supply_in));
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk
  // Counts cycles until reset_active reaches lvl, at most lim
  task automatic wait_rst(input logic lvl, input int lim);
    n = 0;
    while (ract !== lvl && n < lim) begin
      @(posedge clk) #1 n++;
    end
  endtask : wait_rst
  task automatic t_kick_wd();
    run_en = 1;
    wait_rst(1, 4 * WD);
    chk("kick_quiet", 4 * WD, n);
    run_en = 0;
    wait_rst(1, 2 * WD + 40);
    wait_rst(0, 3 * HOLD);
    chk("wd_pulse", 1, n >= HOLD);
    wait_rst(1, 2 * WD);
    chk("wd_repeat", 1, n >= WD - 2 && n <= WD + 4);
    wait_rst(0, 3 * HOLD);
  endtask : t_kick_wd
  task automatic t_src(input int s);
    if (s == 0) mr_n = 0;
    else if (s == 1) aux = 1;
    else sup = 1;
    repeat (10) @(posedge clk);
    #1 chk("src_on", 1, ract);
    chk("src_level", 0, rout);
    {mr_n, aux, sup} = 3'h4;
    wait_rst(0, 3 * HOLD);
    chk("src_hold", 1, n >= HOLD);
    wait_rst(1, 2 * WD);
    chk("wd_cleared", 1, n >= WD - 2 && n <= WD + 4);
    wait_rst(0, 3 * HOLD);
  endtask : t_src
  task automatic t_backup_supply_in();
    bak = 1;
    repeat (10) @(posedge clk);
    #1 chk("backup_supply_in_off", 0, backup_supply_in);
    {sup, mr_n, aux} = 3'h5;
    repeat (HOLD + 10) @(posedge clk);
    #1 chk("battery_mode_out", 1, backup_supply_in);
    chk("backup_supply_in_reset", 1, ract);
    {sup, bak, mr_n, aux} = 4'h2;
    wait_rst(0, 3 * HOLD);
    chk("backup_supply_in_exit", 0, backup_supply_in);
  endtask : t_backup_supply_in
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  // Cycle ceiling against a hang
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      report_and_stop();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    #1 rst = 0;
    chk("power_on", 1, ract);
    wait_rst(0, 200);
    chk("power_hold", 1, n >= HOLD);
    t_kick_wd();
    for (int s = 0; s < 3; s++) t_src(s);
    t_backup_supply_in();
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
